// >>> common/sfr_pkg.sv
package sfr_pkg;

    // ********************************************************
    // register map
    // ********************************************************
    localparam logic [7:0] SFR_ADDR_STATUS1 = 8'h00;
    localparam logic [7:0] SFR_ADDR_STATUS2 = 8'h01;
    localparam logic [7:0] SFR_ADDR_EN1 = 8'h02;
    localparam logic [7:0] SFR_ADDR_EN2 = 8'h03;
    localparam logic [7:0] SFR_ADDR_WR_IDX = 8'h04;
    localparam logic [7:0] SFR_ADDR_LOST = 8'h05;
    localparam logic [7:0] SFR_ADDR_RD_IDX = 8'h06;
    localparam logic [7:0] SFR_ADDR_DATA = 8'h07;
    localparam logic [7:0] SFR_ADDR_TEMP_FRAC = 8'h20;
    localparam logic [7:0] SFR_ADDR_LAST = 8'hFF;
    localparam logic [7:0] SFR_REG_RESET = 8'h00;

    // ********************************************************
    // field positions
    // ********************************************************
    localparam int SFR_EN1_AFULL_BIT = 7;
    localparam int SFR_EN1_NEW_BIT = 6;
    localparam int SFR_EN1_ALC_BIT = 5;
    localparam int SFR_EN1_PROX_BIT = 4;
    localparam int SFR_EN2_TEMP_BIT = 1;
    localparam logic [7:0] SFR_EN1_MASK = 8'hF0;
    localparam logic [7:0] SFR_EN2_MASK = 8'h02;

    // ********************************************************
    // sample store
    // ********************************************************
    localparam int SFR_IDX_W = 5;
    localparam int SFR_SLOTS = 32;
    localparam int SFR_CHAN_W = 18;
    localparam logic [5:0] SFR_FULL_COUNT = 6'h20;
    localparam logic [4:0] SFR_LOST_MAX = 5'h0F;
    localparam logic [2:0] SFR_LAST_BYTE_1CH = 3'h2;
    localparam logic [2:0] SFR_LAST_BYTE_2CH = 3'h5;
    localparam int SFR_BUF_DEPTH = 4;

    // ********************************************************
    // operating modes
    // ********************************************************
    localparam logic [2:0] SFR_MODE_HR = 3'h2;
    localparam logic [2:0] SFR_MODE_SPO2 = 3'h3;
    localparam logic [2:0] SFR_MODE_MULTI = 3'h7;

    typedef struct packed {
        logic [SFR_CHAN_W-1:0] ch_b;
        logic [SFR_CHAN_W-1:0] ch_a;
    } sfr_sample_s;

    typedef struct packed {
        logic ambient_ovf;
        logic proximity;
        logic power_good;
        logic temp_ready;
    } sfr_event_s;

    typedef struct packed {
        logic almost_full;
        logic new_sample;
        logic ambient_ovf;
        logic proximity;
        logic power_good_flag;
        logic temp_ready;
    } sfr_status_s;

endpackage

// >>> hdl/sfr_buf.sv
module sfr_buf
    import sfr_pkg::*;
#(
    parameter int WIDTH = 36,
    parameter int DEPTH = SFR_BUF_DEPTH
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] store_r [DEPTH];
    logic [AW-1:0] head_r;
    logic [AW-1:0] tail_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    assign in_ready_o = (count_r != CNT_FULL);
    assign out_valid_o = (count_r != '0);
    assign out_data_o = store_r[head_r];
    assign push = ce_i & in_valid_i & in_ready_o;
    assign pop = ce_i & out_valid_o & out_ready_i;

    // ********************************************************
    // storage
    // ********************************************************
    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            store_r[tail_r] <= in_data_i;
        end
    end

    // ********************************************************
    // pointers and level
    // ********************************************************
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            head_r <= '0;
            tail_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (push)
            begin
                tail_r <= tail_r + 1'b1;
            end
            if (pop)
            begin
                head_r <= head_r + 1'b1;
            end
            if (push & ~pop)
            begin
                count_r <= count_r + 1'b1;
            end
            else if (pop & ~push)
            begin
                count_r <= count_r - 1'b1;
            end
        end
    end

endmodule

// >>> hdl/sfr_top.sv
// Overview of operation
// - status or source-register read releases the interrupt pin high
// - any clearing read zeroes every interrupt status bit together
// - enable bits at 0x02 and 0x03 gate sources; both reset to zero
// - power-good interrupt has no enable and always reaches the pin
// - brownout reset leaves every maskable source disabled
// - write index advances per push; host writes only in modes 010/011/111
// - full without wrap: drop sample, count it, saturate at 0xF
// - lost-sample count clears when a data-port read pops a sample
// - read index advances per pop; host may rewrite it for rereads
// - circular store holds 32 samples of one or two 3-byte channels
// - burst read of data port 0x07 keeps the address fixed
// - other registers increment the address after each burst byte
// - address stops at 0xFF, no wrap to 0x00, reads return 0x00
// - proximity mode entry or exit with its enable empties the store
// - channel data right-justified, msb at bit 17, bits 23:18 zero
// - two-channel sample is two triplets, six byte reads
// - read index advances once the first byte of a sample is read
// - wrap set: full store keeps writing; clear: store stops updating
// - almost-full fires when empty slots equal the 4-bit threshold
// - power cycle or undervoltage clears both indices
module sfr_top
    import sfr_pkg::*;
#(
    parameter int BUF_DEPTH = SFR_BUF_DEPTH
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // register port
    input wire logic addr_load_i,
    input wire logic [7:0] addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // sample push from front end
    input wire logic push_valid_i,
    input wire sfr_sample_s push_data_i,
    output logic push_ready_o,
    // configuration
    input wire logic [2:0] mode_i,
    input wire logic wrap_when_full_i,
    input wire logic [3:0] almost_full_level_i,
    input wire logic prox_mode_i,
    // events
    input wire sfr_event_s events_i,
    // interrupt pin
    output logic int_n_o
);

    localparam int SW = $bits(sfr_sample_s);

    sfr_sample_s mem_r [SFR_SLOTS];
    sfr_sample_s mem_q_r;
    sfr_sample_s hold_r;
    sfr_sample_s buf_data;
    sfr_sample_s src;
    sfr_status_s status_r;
    logic [7:0] addr_r;
    logic [7:0] irq_enable_primary_r;
    logic [7:0] irq_enable_secondary_r;
    logic [SFR_IDX_W-1:0] sample_write_index_r;
    logic [SFR_IDX_W-1:0] sample_read_index_r;
    logic [SFR_IDX_W-1:0] write_index_nxt;
    logic [SFR_IDX_W-1:0] diff;
    logic [4:0] lost_sample_count_r;
    logic full_r;
    logic prox_d_r;
    logic [2:0] byte_sel_r;
    logic [2:0] last_byte;
    logic [7:0] data_byte;
    logic [7:0] rdata_nxt;
    logic [7:0] rdata_r;
    logic rvalid_r;
    logic [5:0] count;
    logic [5:0] count_after;
    logic [5:0] empties;
    logic rd_hit;
    logic wr_hit;
    logic data_rd;
    logic first_byte;
    logic pop;
    logic host_ptr_wr;
    logic mode_ok;
    logic prox_flip;
    logic prox_clear;
    logic buf_valid;
    logic drain_ready;
    logic drain;
    logic do_store;
    logic drop;
    logic afull_ev;
    logic clear_all;
    logic new_sample_irq_on;
    logic ambient_cancel_overflow_irq_on;
    logic proximity_irq_on;
    logic almost_full_irq_on;
    logic temp_irq_on;
    sfr_status_s status_set;

    // ********************************************************
    // input buffer
    // ********************************************************
    sfr_buf #(
        .WIDTH(SW),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .in_valid_i(push_valid_i),
        .in_ready_o(push_ready_o),
        .in_data_i(push_data_i),
        .out_valid_o(buf_valid),
        .out_ready_i(drain_ready),
        .out_data_o(buf_data)
    );

    // ********************************************************
    // decode
    // ********************************************************
    assign rd_hit = ce_i & reg_rd_i;
    assign wr_hit = ce_i & reg_wr_i;
    assign data_rd = rd_hit & (addr_r == SFR_ADDR_DATA);
    assign first_byte = data_rd & (byte_sel_r == 3'h0);
    assign diff = sample_write_index_r - sample_read_index_r;
    assign count = full_r ? SFR_FULL_COUNT : {1'b0, diff};
    assign pop = first_byte & (count != 6'h00);
    assign host_ptr_wr = wr_hit & ((addr_r == SFR_ADDR_WR_IDX)
        | (addr_r == SFR_ADDR_LOST) | (addr_r == SFR_ADDR_RD_IDX));
    assign mode_ok = (mode_i == SFR_MODE_HR) | (mode_i == SFR_MODE_SPO2)
        | (mode_i == SFR_MODE_MULTI);
    assign new_sample_irq_on = irq_enable_primary_r[SFR_EN1_NEW_BIT];
    assign ambient_cancel_overflow_irq_on =
        irq_enable_primary_r[SFR_EN1_ALC_BIT];
    assign proximity_irq_on = irq_enable_primary_r[SFR_EN1_PROX_BIT];
    assign almost_full_irq_on = irq_enable_primary_r[SFR_EN1_AFULL_BIT];
    assign temp_irq_on = irq_enable_secondary_r[SFR_EN2_TEMP_BIT];
    assign prox_flip = ce_i & (prox_mode_i != prox_d_r);
    assign prox_clear = prox_flip & proximity_irq_on;

    // ********************************************************
    // store admission
    // ********************************************************
    assign drain_ready = ~host_ptr_wr & ~prox_clear;
    assign drain = ce_i & buf_valid & drain_ready;
    assign do_store = drain & (~full_r | wrap_when_full_i);
    assign drop = drain & full_r & ~wrap_when_full_i;
    assign write_index_nxt = sample_write_index_r + 1'b1;
    assign count_after = full_r ? SFR_FULL_COUNT : count + 6'h01;
    assign empties = SFR_FULL_COUNT - count_after;
    assign afull_ev = do_store
        & (empties == {2'h0, almost_full_level_i});

    // ********************************************************
    // sample memory
    // ********************************************************
    always_ff @(posedge clk_i)
    begin
        if (do_store)
        begin
            mem_r[sample_write_index_r] <= buf_data;
        end
        if (ce_i)
        begin
            mem_q_r <= mem_r[sample_read_index_r];
        end
    end

    // ********************************************************
    // indices and full flag
    // ********************************************************
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            sample_write_index_r <= '0;
            sample_read_index_r <= '0;
            full_r <= 1'b0;
            prox_d_r <= 1'b0;
        end
        else if (ce_i)
        begin
            prox_d_r <= prox_mode_i;
            if (prox_clear)
            begin
                sample_read_index_r <= sample_write_index_r;
                full_r <= 1'b0;
            end
            else if (host_ptr_wr & (addr_r == SFR_ADDR_WR_IDX))
            begin
                if (mode_ok)
                begin
                    sample_write_index_r <= reg_wdata_i[SFR_IDX_W-1:0];
                    full_r <= 1'b0;
                end
            end
            else if (host_ptr_wr & (addr_r == SFR_ADDR_RD_IDX))
            begin
                sample_read_index_r <= reg_wdata_i[SFR_IDX_W-1:0];
                full_r <= 1'b0;
            end
            else
            begin
                if (do_store)
                begin
                    sample_write_index_r <= write_index_nxt;
                end
                if (pop | (do_store & full_r))
                begin
                    sample_read_index_r <= sample_read_index_r + 1'b1;
                end
                if (pop & ~do_store)
                begin
                    full_r <= 1'b0;
                end
                else if (do_store & ~pop & ~full_r
                    & (write_index_nxt == sample_read_index_r))
                begin
                    full_r <= 1'b1;
                end
            end
        end
    end

    // ********************************************************
    // lost-sample count
    // ********************************************************
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            lost_sample_count_r <= '0;
        end
        else if (ce_i)
        begin
            if (host_ptr_wr & (addr_r == SFR_ADDR_LOST))
            begin
                lost_sample_count_r <= reg_wdata_i[4:0];
            end
            else if (pop)
            begin
                lost_sample_count_r <= '0;
            end
            else if (drop & (lost_sample_count_r < SFR_LOST_MAX))
            begin
                lost_sample_count_r <= lost_sample_count_r + 1'b1;
            end
        end
    end

    // ********************************************************
    // enables
    // ********************************************************
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            irq_enable_primary_r <= SFR_REG_RESET;
            irq_enable_secondary_r <= SFR_REG_RESET;
        end
        else if (wr_hit)
        begin
            if (addr_r == SFR_ADDR_EN1)
            begin
                irq_enable_primary_r <= reg_wdata_i & SFR_EN1_MASK;
            end
            if (addr_r == SFR_ADDR_EN2)
            begin
                irq_enable_secondary_r <= reg_wdata_i & SFR_EN2_MASK;
            end
        end
    end

    // ********************************************************
    // status flags and pin
    // ********************************************************
    assign clear_all = rd_hit & ((addr_r == SFR_ADDR_STATUS1)
        | (addr_r == SFR_ADDR_STATUS2) | (addr_r == SFR_ADDR_DATA)
        | (addr_r == SFR_ADDR_TEMP_FRAC));

    always_comb
    begin
        status_set = '0;
        status_set.almost_full = afull_ev & almost_full_irq_on;
        status_set.new_sample = do_store & new_sample_irq_on;
        status_set.ambient_ovf = events_i.ambient_ovf
            & ambient_cancel_overflow_irq_on;
        status_set.proximity = events_i.proximity & proximity_irq_on;
        status_set.power_good_flag = events_i.power_good;
        status_set.temp_ready = events_i.temp_ready & temp_irq_on;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            status_r <= '0;
        end
        else if (ce_i)
        begin
            // set wins over a same-cycle clear
            status_r <= (clear_all ? '0 : status_r) | status_set;
        end
    end

    assign int_n_o = ~(|status_r);

    // ********************************************************
    // data port byte walk
    // ********************************************************
    assign last_byte = (mode_i == SFR_MODE_HR) ? SFR_LAST_BYTE_1CH
        : SFR_LAST_BYTE_2CH;
    assign src = first_byte ? mem_q_r : hold_r;

    always_comb
    begin
        case (byte_sel_r)
            3'h0: data_byte = {6'h00, src.ch_a[17:16]};
            3'h1: data_byte = src.ch_a[15:8];
            3'h2: data_byte = src.ch_a[7:0];
            3'h3: data_byte = {6'h00, src.ch_b[17:16]};
            3'h4: data_byte = src.ch_b[15:8];
            3'h5: data_byte = src.ch_b[7:0];
            default: data_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            byte_sel_r <= '0;
            hold_r <= '0;
        end
        else if (ce_i)
        begin
            if (addr_load_i)
            begin
                byte_sel_r <= '0;
            end
            else if (data_rd)
            begin
                byte_sel_r <= (byte_sel_r >= last_byte) ? 3'h0
                    : byte_sel_r + 1'b1;
            end
            if (first_byte)
            begin
                hold_r <= mem_q_r;
            end
        end
    end

    // ********************************************************
    // address pointer
    // ********************************************************
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            addr_r <= SFR_REG_RESET;
        end
        else if (ce_i)
        begin
            if (addr_load_i)
            begin
                addr_r <= addr_i;
            end
            else if ((rd_hit | wr_hit) & (addr_r != SFR_ADDR_DATA)
                & (addr_r != SFR_ADDR_LAST))
            begin
                addr_r <= addr_r + 1'b1;
            end
        end
    end

    // ********************************************************
    // read data
    // ********************************************************
    always_comb
    begin
        case (addr_r)
            SFR_ADDR_STATUS1: rdata_nxt = {status_r.almost_full,
                status_r.new_sample, status_r.ambient_ovf,
                status_r.proximity, 3'h0, status_r.power_good_flag};
            SFR_ADDR_STATUS2: rdata_nxt = {6'h00, status_r.temp_ready, 1'b0};
            SFR_ADDR_EN1: rdata_nxt = irq_enable_primary_r;
            SFR_ADDR_EN2: rdata_nxt = irq_enable_secondary_r;
            SFR_ADDR_WR_IDX: rdata_nxt = {3'h0, sample_write_index_r};
            SFR_ADDR_LOST: rdata_nxt = {3'h0, lost_sample_count_r};
            SFR_ADDR_RD_IDX: rdata_nxt = {3'h0, sample_read_index_r};
            SFR_ADDR_DATA: rdata_nxt = data_byte;
            default: rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end
        else if (ce_i)
        begin
            rvalid_r <= reg_rd_i;
            if (reg_rd_i)
            begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    assign reg_rdata_o = rdata_r;
    assign reg_rvalid_o = rvalid_r;

endmodule

// >>> verification/sfr_monitor.sv
module sfr_chk
    import sfr_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // register port
    input wire logic addr_load_i,
    input wire logic [7:0] addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    // samples, events, pin
    input wire logic push_valid_i,
    input wire logic push_ready_o,
    input wire sfr_event_s events_i,
    input wire logic int_n_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    // ********
    // properties
    // ********
    property p_rv; reg_rd_i |=> reg_rvalid_o; endproperty
    a_rv: assert property (p_rv)
        else $error("read not answered");
    property p_src; reg_rvalid_o |-> $past(reg_rd_i); endproperty
    a_src: assert property (p_src)
        else $error("answer without read");
    property p_hold; !reg_rvalid_o |-> $stable(reg_rdata_o); endproperty
    a_hold: assert property (p_hold)
        else $error("read data moved");
    property p_pg; events_i.power_good |=> !int_n_o; endproperty
    a_pg: assert property (p_pg)
        else $error("power good not on pin");
    property p_clr;
        addr_load_i && !push_valid_i && (addr_i == SFR_ADDR_STATUS1
            || addr_i == SFR_ADDR_DATA) ##1 !push_valid_i ##1 reg_rd_i
            && !push_valid_i && events_i == '0 |=> int_n_o;
    endproperty
    a_clr: assert property (p_clr)
        else $error("pin not released");
    property p_unmap;
        addr_load_i && addr_i == 8'h40 ##2 reg_rd_i |=> reg_rdata_o == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap)
        else $error("unmapped read not zero");
    property p_mask;
        $fell(sys_rst_i) ##0 (!reg_wr_i && !events_i.power_good) [*4]
            |-> int_n_o;
    endproperty
    a_mask: assert property (p_mask)
        else $error("source enabled after reset");
    property p_rdy; !push_valid_i [*3] |-> push_ready_o; endproperty
    a_rdy: assert property (p_rdy)
        else $error("buffer not draining");
    c_int: cover property (!int_n_o);
    c_rd: cover property (reg_rvalid_o);
    c_full: cover property (push_valid_i && !push_ready_o);
endmodule

bind sfr_top sfr_chk chk_u (.clk_i, .sys_rst_i, .addr_load_i, .addr_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .push_valid_i,
    .push_ready_o, .events_i, .int_n_o);

// >>> verification/sfr_host.sv
module sfr_host
(
    // clock
    input wire logic clk_i,
    // register port
    output logic addr_load_o,
    output logic [7:0] addr_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_rd_o,
    input wire logic [7:0] reg_rdata_i,
    input wire logic reg_rvalid_i
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        addr_load_o = 1'b0;
        addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o = 1'b0;
    end

    // every task starts and ends just after an edge
    task automatic adr(input logic [7:0] a);
        addr_load_o = 1'b1;
        addr_o = a;
        @(posedge clk_i) #1;
        addr_load_o = 1'b0;
        addr_o = ~a;
        @(posedge clk_i) #1;
    endtask

    task automatic wr(input logic [7:0] v);
        reg_wr_o = 1'b1;
        reg_wdata_o = v;
        @(posedge clk_i) #1;
        reg_wr_o = 1'b0;
        reg_wdata_o = ~v;
        @(posedge clk_i) #1;
    endtask

    // one byte per request
    task automatic rd(output logic [7:0] v);
        reg_rd_o = 1'b1;
        @(posedge clk_i) #1;
        reg_rd_o = 1'b0;
        @(negedge clk_i);
        v = reg_rvalid_i ? reg_rdata_i : 8'hxx;
        @(posedge clk_i) #1;
    endtask
endmodule

// >>> verification/tb.sv
module tb
    import sfr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_i;
    logic sys_rst_i;
    logic addr_load_i;
    logic [7:0] addr_i;
    logic reg_wr_i;
    logic [7:0] reg_wdata_i;
    logic reg_rd_i;
    logic [7:0] reg_rdata_o;
    logic reg_rvalid_o;
    logic push_valid_i;
    sfr_sample_s push_data_i;
    logic push_ready_o;
    logic [2:0] mode_i;
    logic wrap_when_full_i;
    logic [3:0] almost_full_level_i;
    logic prox_mode_i;
    sfr_event_s events_i;
    logic int_n_o;
    logic ce_i;
    logic [2:0] modes [3] = '{SFR_MODE_HR, SFR_MODE_SPO2, SFR_MODE_MULTI};
    int errors;
    int checks_done;

    sfr_top dut_u (.clk_i, .sys_rst_i, .ce_i, .addr_load_i, .addr_i,
        .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o,
        .push_valid_i, .push_data_i, .push_ready_o, .mode_i,
        .wrap_when_full_i, .almost_full_level_i, .prox_mode_i, .events_i,
        .int_n_o);

    sfr_host host_u (.clk_i, .addr_load_o(addr_load_i), .addr_o(addr_i),
        .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i),
        .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o));

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // ********
    // helpers
    // ********
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic rr(input logic [7:0] exp);
        logic [7:0] v;
        host_u.rd(v);
        chk(v, exp);
    endtask

    task automatic rd_at(input logic [7:0] a, input logic [7:0] exp);
        host_u.adr(a);
        rr(exp);
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic rst();
        sys_rst_i = 1'b1;
        wt(12);
        sys_rst_i = 1'b0;
    endtask

    task automatic ev(input sfr_event_s s);
        events_i = s;
        wt(1);
        events_i = '0;
        wt(1);
    endtask

    task automatic clr();
        host_u.adr(SFR_ADDR_WR_IDX);
        repeat (3) host_u.wr(8'h00);
    endtask

    task automatic fin(input string s);
        $display("test done: %s", s);
    endtask

    function automatic sfr_sample_s smp(input int k);
        smp.ch_a = {2'h2, 8'(k), 8'h5A};
        smp.ch_b = {2'h1, 8'hA5, 8'(k)};
    endfunction

    task automatic rsmp(input int k);
        sfr_sample_s s;
        s = smp(k);
        rr({6'h00, s.ch_a[17:16]});
        rr(s.ch_a[15:8]);
        rr(s.ch_a[7:0]);
        rr({6'h00, s.ch_b[17:16]});
        rr(s.ch_b[15:8]);
        rr(s.ch_b[7:0]);
    endtask

    task automatic push(input int k0, input int n);
        int k;
        k = k0;
        push_valid_i = 1'b1;
        while (k < k0 + n)
        begin
            push_data_i = smp(k);
            @(negedge clk_i);
            if (push_ready_o === 1'b1)
                k++;
            wt(1);
        end
        push_valid_i = 1'b0;
        push_data_i = ~push_data_i;
        wt(3);
    endtask

    initial
    begin
        #100_000;
        errors++;
        print_verdict();
    end

    // ********
    // tests
    // ********
    initial
    begin
        errors = 0;
        checks_done = 0;
        push_valid_i = 1'b0;
        push_data_i = '0;
        mode_i = SFR_MODE_SPO2;
        wrap_when_full_i = 1'b0;
        almost_full_level_i = 4'h0;
        ce_i = 1'b1;
        prox_mode_i = 1'b0;
        events_i = '0;
        rst();
        ev(4'hD);
        chk(8'(int_n_o), 8'h01);
        host_u.adr(SFR_ADDR_EN1);
        repeat (3) rr(8'h00);
        ev(4'h2);
        chk(8'(int_n_o), 8'h00);
        rd_at(SFR_ADDR_STATUS1, 8'h01);
        chk(8'(int_n_o), 8'h01);
        rd_at(SFR_ADDR_STATUS1, 8'h00);
        rd_at(8'h40, 8'h00);
        fin("reset and masking");
        foreach (modes[i])
        begin
            mode_i = modes[i];
            host_u.adr(SFR_ADDR_WR_IDX);
            host_u.wr(8'(modes[i]));
            rd_at(SFR_ADDR_WR_IDX, 8'(modes[i]));
        end
        mode_i = 3'h1;
        host_u.adr(SFR_ADDR_WR_IDX);
        host_u.wr(8'h1E);
        rd_at(SFR_ADDR_WR_IDX, 8'h07);
        mode_i = SFR_MODE_SPO2;
        clr();
        host_u.adr(SFR_ADDR_EN1);
        host_u.wr(8'hF0);
        host_u.wr(8'h02);
        host_u.adr(SFR_ADDR_EN1);
        ce_i = 1'b0;
        host_u.wr(8'h00);
        ce_i = 1'b1;
        rr(8'hF0);
        rr(8'h02);
        fin("modes and enables");
        push(0, 2);
        chk(8'(int_n_o), 8'h00);
        rd_at(SFR_ADDR_WR_IDX, 8'h02);
        host_u.adr(SFR_ADDR_DATA);
        rsmp(0);
        rsmp(1);
        chk(8'(int_n_o), 8'h01);
        rd_at(SFR_ADDR_RD_IDX, 8'h02);
        host_u.adr(SFR_ADDR_RD_IDX);
        host_u.wr(8'h00);
        host_u.adr(SFR_ADDR_DATA);
        rsmp(0);
        fin("sample path");
        clr();
        push(0, 49);
        host_u.adr(SFR_ADDR_WR_IDX);
        rr(8'h00);
        rr(8'h0F);
        rr(8'h00);
        rd_at(SFR_ADDR_STATUS1, 8'hC0);
        host_u.adr(SFR_ADDR_DATA);
        rsmp(0);
        host_u.adr(SFR_ADDR_LOST);
        rr(8'h00);
        rr(8'h01);
        wrap_when_full_i = 1'b1;
        push(49, 2);
        host_u.adr(SFR_ADDR_WR_IDX);
        rr(8'h02);
        rr(8'h00);
        rr(8'h02);
        fin("overflow and wrap");
        push(60, 3);
        prox_mode_i = 1'b1;
        wt(3);
        push(63, 1);
        host_u.adr(SFR_ADDR_WR_IDX);
        rr(8'h06);
        rr(8'h00);
        rr(8'h05);
        prox_mode_i = 1'b0;
        fin("proximity clear");
        rst();
        host_u.adr(SFR_ADDR_EN1);
        repeat (5) rr(8'h00);
        fin("second reset");
        print_verdict();
    end
endmodule
